// [core/rsq_pkg.sv]
// Package for the reset status and release sequencer.
// Assumes one 125 MHz clock; shared constants are named here once.
package rsq_pkg;
   // Register map (byte addresses on classic Wishbone)
   localparam logic [3:0] ADDR_CAUSE = 4'h0;
   localparam logic [3:0] ADDR_OSC = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   // Cause register bit positions
   localparam int B_TRAP = 15;
   localparam int B_BADOP = 14;
   localparam int B_SWBOR = 13;
   localparam int B_RETEN = 12;
   localparam int B_CFGMM = 9;
   localparam int B_PMSLP = 8;
   localparam int B_PIN = 7;
   localparam int B_INSTR = 6;
   localparam int B_SWDT = 5;
   localparam int B_WATCHDOG_EXPIRY_FLAG = 4;
   localparam int B_SLEEP = 3;
   localparam int B_IDLE = 2;
   localparam int B_BOR = 1;
   localparam int B_POR = 0;
   // Implemented bits (11:10 read as zero)
   localparam logic [15:0] CAUSE_MASK = 16'hF3FF;
   localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
   // Oscillator register: current oscillator field at 14:12
   localparam int OSC_LSB = 12;
   // Oscillator source codes
   localparam logic [2:0] OSC_FRC = 3'h0;
   localparam logic [2:0] OSC_FRCPLL = 3'h1;
   localparam logic [2:0] OSC_PRI = 3'h2;
   localparam logic [2:0] OSC_PRIPLL = 3'h3;
   localparam logic [2:0] OSC_SOSC = 3'h4;
   localparam logic [2:0] OSC_INTERNAL_LOW_POWER_RC = 3'h5;
   localparam logic [2:0] OSC_EC = 3'h6;
   localparam logic [2:0] OSC_ECPLL = 3'h7;
   // Timing
   localparam int CLK_MHZ = 125;
   localparam int POWER_UP_TIMER_MS = 64;
   localparam int POWER_UP_TIMER_CYC = POWER_UP_TIMER_MS * CLK_MHZ * 1000;
   localparam int POR_US = 2;
   localparam int POR_CYC = POR_US * CLK_MHZ;
   localparam int RC_US = 15;
   localparam int RC_CYC = RC_US * CLK_MHZ;
   localparam int LOCK_US = 128;
   localparam int LOCK_CYC = LOCK_US * CLK_MHZ;
   localparam int OST_PERIODS = 1024;
   localparam int OST_W = 10;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN = 3'b100
   } rsq_state_t;
endpackage

// [core/rsq_sequencer.sv]
// Reset status flags, clock source choice and reset release timing.
// Assumes reset sources and oscillator ticks are synchronous pulses or
// levels already on sys_clk, except the pin reset which is synchronised.
`timescale 1ns/10ps
module rsq_sequencer #(
   parameter int POR_CYCLES = rsq_pkg::POR_CYC,
   parameter int POWER_UP_TIMER_CYCLES = rsq_pkg::POWER_UP_TIMER_CYC,
   parameter int RC_CYCLES = rsq_pkg::RC_CYC,
   parameter int LOCK_CYCLES = rsq_pkg::LOCK_CYC
) (
   // Clock and power-on reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Reset sources and power-save events
   input wire logic master_clear_pin_n,
   input wire logic brown_out_evt,
   input wire logic instr_reset_evt,
   input wire logic watchdog_expiry_evt,
   input wire logic trap_conflict_evt,
   input wire logic bad_opcode_evt,
   input wire logic config_mismatch_evt,
   input wire logic power_save_instruction_sleep_evt,
   input wire logic power_save_instruction_idle_evt,
   // Configuration word bits
   input wire logic [2:0] configured_oscillator_select,
   input wire logic clock_switch_en,
   input wire logic power_up_timer_en,
   input wire logic two_speed_en,
   input wire logic fail_safe_en,
   input wire logic [1:0] watchdog_config_enable,
   // Oscillator subsystem
   input wire logic osc_tick,
   input wire logic pll_locked,
   input wire logic clock_present,
   // Outputs to system
   output logic system_reset_signal,
   output logic cpu_run,
   output logic watchdog_on,
   output logic [2:0] active_osc,
   output logic fail_safe_trap
);
   localparam int CW = 24;
   localparam int OST_CNT_W = rsq_pkg::OST_W + 1;

   function automatic logic [CW-1:0] cyc(input int n);
      cyc = CW'((n < 1) ? 1 : n);
   endfunction

   // Pin reset through three flops; acts once the last two agree
   logic [2:0] pin_sync_reg;
   logic pin_level_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_sync_reg <= 3'h7;
         pin_level_reg <= 1'b1;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], master_clear_pin_n};
         if (pin_sync_reg[2] == pin_sync_reg[1]) begin
            pin_level_reg <= pin_sync_reg[2];
         end
      end
   end
   wire pin_evt = !pin_level_reg;

   // Power-on is modelled by nrst: first cycle after release
   logic por_seen_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         por_seen_reg <= 1'b0;
      end else begin
         por_seen_reg <= 1'b1;
      end
   end
   wire por_evt = !por_seen_reg;

   wire other_evt = pin_evt | instr_reset_evt | watchdog_expiry_evt |
      trap_conflict_evt | bad_opcode_evt | config_mismatch_evt;
   wire any_evt = por_evt | brown_out_evt | other_evt;

   // Bus decode
   wire wb_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
   wire sel_cause = (wb_adr_i == rsq_pkg::ADDR_CAUSE);
   wire sel_osc = (wb_adr_i == rsq_pkg::ADDR_OSC);
   wire sel_stat = (wb_adr_i == rsq_pkg::ADDR_STAT);
   wire wr_cause = wb_req & wb_we_i & sel_cause;
   wire [15:0] be = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Cause flags
   logic [15:0] cause_reg;
   logic [15:0] hw_set;
   logic [15:0] hw_clr;
   logic [15:0] sw_val;
   logic [15:0] cause_next;
   always_comb begin
      hw_set = 16'h0000;
      hw_set[rsq_pkg::B_TRAP] = trap_conflict_evt;
      hw_set[rsq_pkg::B_BADOP] = bad_opcode_evt;
      hw_set[rsq_pkg::B_CFGMM] = config_mismatch_evt;
      hw_set[rsq_pkg::B_PIN] = pin_evt;
      hw_set[rsq_pkg::B_INSTR] = instr_reset_evt;
      hw_set[rsq_pkg::B_WATCHDOG_EXPIRY_FLAG] = watchdog_expiry_evt;
      hw_set[rsq_pkg::B_SLEEP] = power_save_instruction_sleep_evt;
      hw_set[rsq_pkg::B_IDLE] = power_save_instruction_idle_evt;
      hw_set[rsq_pkg::B_BOR] = brown_out_evt | por_evt;
      hw_set[rsq_pkg::B_POR] = por_evt;
      hw_clr = 16'h0000;
      hw_clr[rsq_pkg::B_WATCHDOG_EXPIRY_FLAG] = power_save_instruction_sleep_evt | power_save_instruction_idle_evt;
      // Software write lands first; hardware set wins over any clear
      sw_val = wr_cause ? ((cause_reg & ~be) | (wb_dat_i[15:0] & be))
                        : cause_reg;
      cause_next = ((sw_val & ~hw_clr) | hw_set) & rsq_pkg::CAUSE_MASK;
      if (por_evt) begin
         cause_next = rsq_pkg::CAUSE_POR_VAL;
      end
   end
   // Flags move one cycle after the event raises reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cause_reg <= rsq_pkg::CAUSE_POR_VAL;
      end else begin
         cause_reg <= cause_next;
      end
   end

   assign watchdog_on = (watchdog_config_enable == 2'h3) |
      cause_reg[rsq_pkg::B_SWDT];

   // Sequencer
   rsq_pkg::rsq_state_t state_reg;
   logic [CW-1:0] hold_cnt_reg;
   logic [CW-1:0] clk_cnt_reg;
   logic [OST_CNT_W-1:0] ost_cnt_reg;
   logic [2:0] cur_osc_reg;
   logic src_pll_q;
   logic por_kind_reg;
   logic bor_kind_reg;
   logic fail_safe_clock_monitor_reg;

   wire [CW-1:0] power_up_timer_len = power_up_timer_en ? cyc(POWER_UP_TIMER_CYCLES)
                                              : CW'(0);
   wire [CW-1:0] hold_len = por_evt ? CW'(cyc(POR_CYCLES) + power_up_timer_len) :
      brown_out_evt ? power_up_timer_len : CW'(0);
   wire cfg_load = !clock_switch_en | por_evt | brown_out_evt;
   wire [2:0] sel_osc_src = two_speed_en ? rsq_pkg::OSC_FRC :
      (cfg_load ? configured_oscillator_select : cur_osc_reg);
   wire src_pll = (sel_osc_src == rsq_pkg::OSC_FRCPLL) |
      (sel_osc_src == rsq_pkg::OSC_PRIPLL) |
      (sel_osc_src == rsq_pkg::OSC_ECPLL);
   wire src_rc = (sel_osc_src == rsq_pkg::OSC_FRC) |
      (sel_osc_src == rsq_pkg::OSC_FRCPLL) |
      (sel_osc_src == rsq_pkg::OSC_INTERNAL_LOW_POWER_RC);
   wire src_xtal = (sel_osc_src == rsq_pkg::OSC_PRI) |
      (sel_osc_src == rsq_pkg::OSC_PRIPLL) |
      (sel_osc_src == rsq_pkg::OSC_SOSC);
   // Only POR and BOR restart the oscillator; others add no clock delay
   wire osc_restart = por_evt | brown_out_evt;
   wire [CW-1:0] clk_len = !osc_restart ? CW'(0) :
      CW'((src_rc ? cyc(RC_CYCLES) : CW'(0)) +
      (src_pll ? cyc(LOCK_CYCLES) : CW'(0)));
   wire ost_need = osc_restart & src_xtal;

   wire hold_done = (hold_cnt_reg == CW'(0));
   wire clk_done = (clk_cnt_reg == CW'(0)) &&
      (ost_cnt_reg == OST_CNT_W'(0)) &&
      (!src_pll_q || pll_locked);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= rsq_pkg::ST_HOLD;
         hold_cnt_reg <= {CW{1'b1}};
         clk_cnt_reg <= {CW{1'b1}};
         ost_cnt_reg <= {OST_CNT_W{1'b1}};
         cur_osc_reg <= 3'h0;
         src_pll_q <= 1'b0;
      end else if (any_evt) begin
         state_reg <= rsq_pkg::ST_HOLD;
         hold_cnt_reg <= hold_len;
         // Clock wait starts with the hold, not after it
         clk_cnt_reg <= clk_len;
         ost_cnt_reg <= ost_need ? OST_CNT_W'(rsq_pkg::OST_PERIODS)
                                 : OST_CNT_W'(0);
         cur_osc_reg <= sel_osc_src;
         src_pll_q <= osc_restart & src_pll;
      end else begin
         if (!hold_done) begin
            hold_cnt_reg <= hold_cnt_reg - CW'(1);
         end
         if (clk_cnt_reg != CW'(0)) begin
            clk_cnt_reg <= clk_cnt_reg - CW'(1);
         end
         if (osc_tick && ost_cnt_reg != OST_CNT_W'(0)) begin
            ost_cnt_reg <= ost_cnt_reg - OST_CNT_W'(1);
         end
         if (fail_safe_trap) begin
            cur_osc_reg <= rsq_pkg::OSC_FRC;
         end
         unique case (state_reg)
            rsq_pkg::ST_HOLD: begin
               if (hold_done) begin
                  state_reg <= rsq_pkg::ST_WAIT;
               end
            end
            rsq_pkg::ST_WAIT: begin
               if (clk_done) begin
                  state_reg <= rsq_pkg::ST_RUN;
               end
            end
            rsq_pkg::ST_RUN: begin
               state_reg <= rsq_pkg::ST_RUN;
            end
            default: begin
               state_reg <= rsq_pkg::ST_HOLD;
            end
         endcase
      end
   end

   assign system_reset_signal = any_evt | (state_reg == rsq_pkg::ST_HOLD);
   assign cpu_run = (state_reg == rsq_pkg::ST_RUN);
   assign active_osc = cur_osc_reg;

   // Fail-safe monitor: checks once at release, then keeps watching
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fail_safe_clock_monitor_reg <= 1'b0;
         fail_safe_trap <= 1'b0;
      end else begin
         fail_safe_trap <= 1'b0;
         if (system_reset_signal) begin
            fail_safe_clock_monitor_reg <= 1'b0;
         end else if (fail_safe_en) begin
            fail_safe_clock_monitor_reg <= 1'b1;
            if (!clock_present && cur_osc_reg != rsq_pkg::OSC_FRC) begin
               fail_safe_trap <= 1'b1;
            end
         end
      end
   end

   // Read mux and single-wait ack
   wire [31:0] rd_data = sel_cause ? {16'h0000, cause_reg} :
      sel_osc ? {17'h00000, cur_osc_reg, 12'h000} :
      sel_stat ? {27'h0000000, fail_safe_clock_monitor_reg, hold_done, clk_done,
                  cpu_run, system_reset_signal} : 32'h00000000;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= rd_data;
      end
   end

   a_wdt_forced: assert property (@(posedge sys_clk) disable iff (!nrst)
      watchdog_config_enable == 2'h3 |-> watchdog_on)
      else $error("watchdog not forced on");
   a_por_flags: assert property (@(posedge sys_clk) disable iff (!nrst)
      por_evt |=> cause_reg == rsq_pkg::CAUSE_POR_VAL)
      else $error("power-on flags wrong");
   a_pin_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
      pin_evt |=> cause_reg[rsq_pkg::B_PIN])
      else $error("pin flag not set");
   a_watchdog_expiry_flag_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
      power_save_instruction_idle_evt && !watchdog_expiry_evt && !por_evt
      |=> !cause_reg[rsq_pkg::B_WATCHDOG_EXPIRY_FLAG] && cause_reg[rsq_pkg::B_IDLE])
      else $error("power-save flag handling wrong");
   a_bor_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
      brown_out_evt |=> cause_reg[rsq_pkg::B_BOR])
      else $error("brown-out flag not set");
   a_reset_src: assert property (@(posedge sys_clk) disable iff (!nrst)
      (instr_reset_evt || trap_conflict_evt) |-> system_reset_signal)
      else $error("reset not asserted");
   a_run_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
      cpu_run |-> !system_reset_signal || any_evt)
      else $error("cpu running under reset");
   a_sleep_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
      power_save_instruction_sleep_evt |=> cause_reg[rsq_pkg::B_SLEEP])
      else $error("sleep flag not set");
endmodule

// [dv/rsq_osc_model.sv]
// Behavioural oscillator subsystem facing the reset sequencer.
// Assumes one sys_clk; the bench decides whether the clock is present.
`timescale 1ns/10ps
module rsq_osc_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Bench control
   input wire logic clk_ok,
   // Toward the sequencer
   output logic osc_tick,
   output logic pll_locked,
   output logic clock_present
);
   logic [4:0] lock_reg;
   assign clock_present = clk_ok;
   // Lock is lost with the clock, so a dead oscillator never looks locked
   assign pll_locked = lock_reg[4] & clk_ok;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         osc_tick <= 1'b0;
         lock_reg <= 5'h00;
      end else begin
         osc_tick <= clk_ok;
         if (!lock_reg[4] && clk_ok) begin
            lock_reg <= lock_reg + 5'h01;
         end
      end
   end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the reset status and release sequencer.
// Assumes short delay parameters; the oscillator ticks every cycle until the fail-safe test stops the clock.
`timescale 1ns/10ps
module testbench;
   localparam int PC = 6;
   localparam int PW = 20;
   localparam int BP[7] = '{rsq_pkg::B_BOR, rsq_pkg::B_INSTR,
      rsq_pkg::B_WATCHDOG_EXPIRY_FLAG, rsq_pkg::B_TRAP, rsq_pkg::B_BADOP,
      rsq_pkg::B_CFGMM, rsq_pkg::B_PIN};
   localparam int ORD[8] = '{1, 2, 3, 4, 5, 6, 0, 1};
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, pin_n = 1'b1, slp = 1'b0, idl = 1'b0, swen = 1'b1;
   logic fsen = 1'b0, clk_ok = 1'b1, osc_tick, pll_locked, clock_present;
   logic tsen = 1'b0, pute = 1'b1;
   logic [5:0] evt = 6'h00;
   logic [2:0] osel = rsq_pkg::OSC_PRI;
   logic [1:0] wdc = 2'h3;
   logic system_reset_signal, cpu_run, watchdog_on, fail_safe_trap;
   logic [2:0] active_osc;
   logic [15:0] rs = 16'h000E;
   int n_fail = 0;
   int cmp_count = 0;
   rsq_osc_model rsq_osc_model_inst (.sys_clk(sys_clk), .nrst(nrst),
      .clk_ok(clk_ok), .osc_tick(osc_tick), .pll_locked(pll_locked),
      .clock_present(clock_present));
   rsq_sequencer #(.POR_CYCLES(PC), .POWER_UP_TIMER_CYCLES(PW), .RC_CYCLES(5),
      .LOCK_CYCLES(8)) rsq_sequencer_inst (.sys_clk(sys_clk), .nrst(nrst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .master_clear_pin_n(pin_n),
      .brown_out_evt(evt[0]), .instr_reset_evt(evt[1]),
      .watchdog_expiry_evt(evt[2]), .trap_conflict_evt(evt[3]),
      .bad_opcode_evt(evt[4]), .config_mismatch_evt(evt[5]),
      .power_save_instruction_sleep_evt(slp), .power_save_instruction_idle_evt(idl),
      .configured_oscillator_select(osel), .clock_switch_en(swen),
      .power_up_timer_en(pute), .two_speed_en(tsen), .fail_safe_en(fsen),
      .watchdog_config_enable(wdc), .osc_tick(osc_tick),
      .pll_locked(pll_locked), .clock_present(clock_present),
      .system_reset_signal(system_reset_signal), .cpu_run(cpu_run),
      .watchdog_on(watchdog_on), .active_osc(active_osc),
      .fail_safe_trap(fail_safe_trap));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Reset kind and clock switch enable decide whether the configured source is reloaded
   function automatic logic [2:0] exp_osc(input logic pb, input logic sw,
      input logic [2:0] cur, input logic [2:0] cfg);
      return (pb || !sw) ? cfg : cur;
   endfunction
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 50) begin
         n_fail++;
         conclude();
      end
   endtask
   // Counts held cycles and total cycles until the CPU is let run
   task automatic wait_run(output int h, output int t);
      logic bad;
      bad = 1'b0;
      h = 0;
      t = 0;
      while (cpu_run !== 1'b1 && t < 4000) begin
         @(posedge sys_clk);
         t++;
         if (system_reset_signal === 1'b1) h++;
         if (cpu_run === 1'b1 && system_reset_signal === 1'b1) bad = 1'b1;
      end
      chk("run_in_reset", 0, bad);
      if (t >= 4000) begin
         n_fail++;
         conclude();
      end
   endtask
   task automatic fire(input int k);
      int n;
      @(posedge sys_clk);
      if (k == 6) pin_n <= 1'b0;
      else evt[k] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      pin_n <= 1'b1;
      evt <= 6'h00;
      for (n = 0; n < 10 && system_reset_signal !== 1'b1; n++)
         @(posedge sys_clk);
      chk("reset_asserted", 1, system_reset_signal);
   endtask
   initial begin
      logic [31:0] q;
      logic [2:0] cur;
      int h, t, i, k;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      wait_run(h, t);
      chk("por_hold", 1, h >= PC + PW);
      chk("ost_wait", 1, t >= rsq_pkg::OST_PERIODS);
      chk("parallel", 1, t < rsq_pkg::OST_PERIODS + PC + PW);
      wb(0, rsq_pkg::ADDR_CAUSE, 0, q);
      chk("cause_por", rsq_pkg::CAUSE_POR_VAL, q[15:0]);
      wb(0, rsq_pkg::ADDR_OSC, 0, q);
      chk("osc_por", rsq_pkg::OSC_PRI, q[14:12]);
      chk("wdt_forced", 1, watchdog_on);
      $display("test power_on done");
      wb(1, 4'hC, 32'hFFFF_FFFF, q);
      wb(0, 4'hC, 0, q);
      chk("unmapped", 0, q);
      for (i = 0; i < 6; i++) begin
         rs = lfsr(rs);
         wb(1, rsq_pkg::ADDR_CAUSE, {16'h0000, rs}, q);
         chk("no_sw_reset", 0, system_reset_signal);
         wb(0, rsq_pkg::ADDR_CAUSE, 0, q);
         chk("cause_rw", rs & rsq_pkg::CAUSE_MASK, q[15:0]);
      end
      wb(1, rsq_pkg::ADDR_CAUSE, 0, q);
      chk("wdt_forced_off_bit", 1, watchdog_on);
      wdc <= 2'h0;
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk("wdt_sw_off", 0, watchdog_on);
      wb(1, rsq_pkg::ADDR_CAUSE, 32'h0000_0020, q);
      @(posedge sys_clk);
      chk("wdt_sw_on", 1, watchdog_on);
      $display("test software_access done");
      cur = rsq_pkg::OSC_PRI;
      osel <= rsq_pkg::OSC_EC;
      for (i = 0; i < 8; i++) begin
         k = ORD[i];
         if (i == 7) begin
            swen <= 1'b0;
            osel <= rsq_pkg::OSC_FRC;
         end
         wb(1, rsq_pkg::ADDR_CAUSE, 0, q);
         fire(k);
         wait_run(h, t);
         if (k == 0) chk("bor_hold", 1, h >= PW);
         else chk("short_hold", 1, h < PW);
         wb(0, rsq_pkg::ADDR_CAUSE, 0, q);
         chk("cause_flag", 32'h1 << BP[k], q);
         cur = exp_osc(k == 0, swen, cur, osel);
         chk("osc_sel", cur, active_osc);
      end
      $display("test reset_kinds done");
      wb(1, rsq_pkg::ADDR_CAUSE, 32'h1 << rsq_pkg::B_WATCHDOG_EXPIRY_FLAG, q);
      @(posedge sys_clk);
      slp <= 1'b1;
      @(posedge sys_clk);
      slp <= 1'b0;
      idl <= 1'b1;
      @(posedge sys_clk);
      idl <= 1'b0;
      wb(0, rsq_pkg::ADDR_CAUSE, 0, q);
      chk("power_save", 32'h000C, q);
      chk("no_save_reset", 0, system_reset_signal);
      $display("test power_save done");
      tsen <= 1'b1;
      pute <= 1'b0;
      osel <= rsq_pkg::OSC_PRI;
      fire(0);
      wait_run(h, t);
      chk("power_up_timer_off", 1, h < PW);
      chk("two_speed", rsq_pkg::OSC_FRC, active_osc);
      tsen <= 1'b0;
      pute <= 1'b1;
      $display("test two_speed done");
      swen <= 1'b1;
      fsen <= 1'b1;
      osel <= rsq_pkg::OSC_EC;
      fire(0);
      wait_run(h, t);
      clk_ok <= 1'b0;
      for (i = 0; i < 10 && fail_safe_trap !== 1'b1; i++)
         @(posedge sys_clk);
      chk("fs_trap", 1, fail_safe_trap);
      repeat (2) @(posedge sys_clk);
      chk("fs_osc", rsq_pkg::OSC_FRC, active_osc);
      $display("test fail_safe done");
      conclude();
   end
endmodule
